// file: design/tlie_pkg.sv
// constants, register map and state codes for the top-level interrupt enable block
package tlie_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned LINE_W = 17;
    localparam int unsigned TMR_W  = 7;

    // line positions in the enable registers
    localparam int unsigned BIT_DEBUG         = 16;
    localparam int unsigned BIT_EXT_PIN_D     = 15;
    localparam int unsigned BIT_EXT_PIN_C     = 14;
    localparam int unsigned BIT_EXT_PIN_B     = 13;
    localparam int unsigned BIT_EXT_PIN_A     = 12;
    localparam int unsigned BIT_CONVERTER     = 11;
    localparam int unsigned BIT_RADIO_RECEIVE = 10;
    localparam int unsigned BIT_RADIO_TRANSMIT = 9;
    localparam int unsigned BIT_RADIO_TIMER   = 8;
    localparam int unsigned BIT_SECURITY      = 7;
    localparam int unsigned BIT_SERIAL_TWO    = 6;
    localparam int unsigned BIT_SERIAL_ONE    = 5;
    localparam int unsigned BIT_SLEEP_TIMER   = 4;
    localparam int unsigned BIT_BASEBAND      = 3;
    localparam int unsigned BIT_MANAGEMENT    = 2;
    localparam int unsigned BIT_TIMER_TWO     = 1;
    localparam int unsigned BIT_TIMER_ONE     = 0;

    // timer second-level flag positions; bit 5 is not implemented
    localparam int unsigned TMR_TRIGGER = 6;
    localparam int unsigned TMR_CC4     = 4;
    localparam int unsigned TMR_CC3     = 3;
    localparam int unsigned TMR_CC2     = 2;
    localparam int unsigned TMR_CC1     = 1;
    localparam int unsigned TMR_UPDATE  = 0;
    localparam logic [TMR_W-1:0] TMR_IMPL_MASK = 7'h5F;

    // register byte addresses
    localparam logic [31:0] ADDR_EN_SET     = 32'hE000E100;
    localparam logic [31:0] ADDR_EN_CLEAR   = 32'hE000E180;
    localparam logic [31:0] ADDR_TMR1_FLAG  = 32'hE000E400;
    localparam logic [31:0] ADDR_TMR1_CFG   = 32'hE000E404;
    localparam logic [31:0] ADDR_TMR2_FLAG  = 32'hE000E408;
    localparam logic [31:0] ADDR_TMR2_CFG   = 32'hE000E40C;
    localparam logic [31:0] ADDR_IRQ_STATUS = 32'hE000E410;
    localparam logic [31:0] ADDR_IRQ_MASK   = 32'hE000E414;

    localparam logic [LINE_W-1:0] RESET_ENABLE = 17'h00000;
    localparam logic [LINE_W-1:0] RESET_STATUS = 17'h00000;
    localparam logic [LINE_W-1:0] RESET_MASK   = 17'h00000;
    localparam logic [TMR_W-1:0]  RESET_TMR    = 7'h00;
    localparam logic [DATA_W-1:0] READ_ZERO    = 32'h00000000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK  = 2'b10
    } tlie_bus_state_type;

endpackage

// file: design/tlie_ifs.sv
// carriers between the register slave, the timer flag units and the top
`timescale 1ns/1ps
interface tlie_cmd_if;
    logic                        wr_commit;
    logic [31:0]                 addr;
    logic [tlie_pkg::DATA_W-1:0] wdata;
    logic [tlie_pkg::DATA_W-1:0] wmask;
    logic [tlie_pkg::DATA_W-1:0] rdata;
    modport slave (output wr_commit, addr, wdata, wmask, input rdata);
    modport regs  (input wr_commit, addr, wdata, wmask, output rdata);
endinterface // tlie_cmd_if

interface tlie_flag_if;
    logic                       flag_clr_wr;
    logic                       cfg_wr;
    logic [tlie_pkg::TMR_W-1:0] wdata;
    logic [tlie_pkg::TMR_W-1:0] wmask;
    logic [tlie_pkg::TMR_W-1:0] flags;
    logic [tlie_pkg::TMR_W-1:0] cfg;
    logic                       line;
    modport ctrl (output flag_clr_wr, cfg_wr, wdata, wmask, input flags, cfg, line);
    modport unit (input flag_clr_wr, cfg_wr, wdata, wmask, output flags, cfg, line);
endinterface // tlie_flag_if

// file: design/tlie_avmm_slave.sv
// avalon-mm slave front end: one wait cycle, write commits on the accept edge
`timescale 1ns/1ps
module tlie_avmm_slave
(
    input  wire logic                        clock,
    input  wire logic                        nrst,
    input  wire logic                        ce,
    input  wire logic [31:0]                 avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [tlie_pkg::DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic      [tlie_pkg::DATA_W-1:0] avs_readdata,
    output logic                             avs_waitrequest,
    tlie_cmd_if.slave                        cmd
);
    tlie_pkg::tlie_bus_state_type state_q;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q         <= tlie_pkg::ST_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= tlie_pkg::READ_ZERO;
        end
        else if (ce)
        begin
            unique case (state_q)
                tlie_pkg::ST_IDLE:
                begin
                    if (avs_read || avs_write)
                    begin
                        state_q         <= tlie_pkg::ST_ACK;
                        avs_waitrequest <= 1'b0;
                        avs_readdata    <= avs_read ? cmd.rdata : tlie_pkg::READ_ZERO;
                    end
                end
                tlie_pkg::ST_ACK:
                begin
                    state_q         <= tlie_pkg::ST_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default:
                begin
                    state_q         <= tlie_pkg::ST_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // the master holds the request until it sees waitrequest low, so address is stable
    assign cmd.wr_commit = ce && avs_write && (state_q == tlie_pkg::ST_ACK);
    assign cmd.addr      = avs_address;
    assign cmd.wdata     = avs_writedata;
    assign cmd.wmask     = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
endmodule // tlie_avmm_slave

// file: design/tlie_timer_flags.sv
// second-level flag set and enable for one general-purpose timer
`timescale 1ns/1ps
module tlie_timer_flags
(
    input  wire logic                       clock,
    input  wire logic                       nrst,
    input  wire logic                       ce,
    input  wire logic [tlie_pkg::TMR_W-1:0] events,
    tlie_flag_if.unit                       fl
);
    logic [tlie_pkg::TMR_W-1:0] flags_q;
    logic [tlie_pkg::TMR_W-1:0] cfg_q;
    logic [tlie_pkg::TMR_W-1:0] clr_bits;

    assign clr_bits = fl.flag_clr_wr ? (fl.wdata & fl.wmask) : tlie_pkg::RESET_TMR;

    // flags set regardless of cfg; a new event beats a same-cycle clear
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            flags_q <= tlie_pkg::RESET_TMR;
        else if (ce)
            flags_q <= ((flags_q & ~clr_bits) | events) & tlie_pkg::TMR_IMPL_MASK;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            cfg_q <= tlie_pkg::RESET_TMR;
        else if (ce && fl.cfg_wr)
            cfg_q <= ((cfg_q & ~fl.wmask) | (fl.wdata & fl.wmask)) & tlie_pkg::TMR_IMPL_MASK;
    end

    assign fl.flags = flags_q;
    assign fl.cfg   = cfg_q;
    assign fl.line  = |(flags_q & cfg_q);
endmodule // tlie_timer_flags

// file: design/tlie_top.sv
// top-level interrupt enable block with avalon-mm registers and timer flag merging
// How it works
// - set-enable write ones enable lines; reset clears
// - clear-enable write ones disable matching lines
// - zero bits leave enables unchanged
// - bit16 debug, bits15..12 pins D..A
// - bits11..7 converter, radio rx/tx/timer, security
// - bits6..0 serial2, serial1, sleep, baseband, management, timers
// - timer lines from own seven-bit flag sets
// - clear register same layout; bits31..17 reserved
// - flags set on event, cleared by write-one
// - enabled flags ORed as level line
`timescale 1ns/1ps
module tlie_top #(
    parameter int unsigned ADDR_W = 32
)
(
    input  wire logic                        clock,
    input  wire logic                        nrst,
    input  wire logic                        ce,
    input  wire logic [ADDR_W-1:0]           avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [tlie_pkg::DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic      [tlie_pkg::DATA_W-1:0] avs_readdata,
    output logic                             avs_waitrequest,
    input  wire logic                        debug_line,
    input  wire logic                        ext_pin_d_line,
    input  wire logic                        ext_pin_c_line,
    input  wire logic                        ext_pin_b_line,
    input  wire logic                        ext_pin_a_line,
    input  wire logic                        converter_line,
    input  wire logic                        radio_receive_line,
    input  wire logic                        radio_transmit_line,
    input  wire logic                        radio_timer_line,
    input  wire logic                        security_line,
    input  wire logic                        serial_two_line,
    input  wire logic                        serial_one_line,
    input  wire logic                        sleep_timer_line,
    input  wire logic                        baseband_line,
    input  wire logic                        management_line,
    input  wire logic [tlie_pkg::TMR_W-1:0]  timer_two_source,
    input  wire logic [tlie_pkg::TMR_W-1:0]  timer_one_source,
    output logic      [tlie_pkg::LINE_W-1:0] core_irq_q,
    output logic                             irq_q
);
    if (ADDR_W != 32)
    begin : g_addr_check
        $error("ADDR_W must be 32 to reach the printed register addresses");
    end

    tlie_cmd_if  cmd ();
    tlie_flag_if tmr1 ();
    tlie_flag_if tmr2 ();

    logic [tlie_pkg::LINE_W-1:0] lines;
    logic [tlie_pkg::LINE_W-1:0] enable_q;
    logic [tlie_pkg::LINE_W-1:0] status_q;
    logic [tlie_pkg::LINE_W-1:0] mask_q;
    logic [tlie_pkg::LINE_W-1:0] wd;
    logic [tlie_pkg::LINE_W-1:0] wm;
    logic [tlie_pkg::LINE_W-1:0] set_bits;
    logic [tlie_pkg::LINE_W-1:0] clr_bits;
    logic [tlie_pkg::LINE_W-1:0] st_clr_bits;
    logic [tlie_pkg::LINE_W-1:0] request;
    logic [tlie_pkg::DATA_W-1:0] rdata;

    tlie_avmm_slave u_slave (
        .clock           (clock),
        .nrst            (nrst),
        .ce              (ce),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .cmd             (cmd)
    );

    tlie_timer_flags u_tmr1 (
        .clock  (clock),
        .nrst   (nrst),
        .ce     (ce),
        .events (timer_one_source),
        .fl     (tmr1)
    );

    tlie_timer_flags u_tmr2 (
        .clock  (clock),
        .nrst   (nrst),
        .ce     (ce),
        .events (timer_two_source),
        .fl     (tmr2)
    );

    // line assembly
    always_comb
    begin
        lines = tlie_pkg::RESET_ENABLE;
        lines[tlie_pkg::BIT_DEBUG]          = debug_line;
        lines[tlie_pkg::BIT_EXT_PIN_D]      = ext_pin_d_line;
        lines[tlie_pkg::BIT_EXT_PIN_C]      = ext_pin_c_line;
        lines[tlie_pkg::BIT_EXT_PIN_B]      = ext_pin_b_line;
        lines[tlie_pkg::BIT_EXT_PIN_A]      = ext_pin_a_line;
        lines[tlie_pkg::BIT_CONVERTER]      = converter_line;
        lines[tlie_pkg::BIT_RADIO_RECEIVE]  = radio_receive_line;
        lines[tlie_pkg::BIT_RADIO_TRANSMIT] = radio_transmit_line;
        lines[tlie_pkg::BIT_RADIO_TIMER]    = radio_timer_line;
        lines[tlie_pkg::BIT_SECURITY]       = security_line;
        lines[tlie_pkg::BIT_SERIAL_TWO]     = serial_two_line;
        lines[tlie_pkg::BIT_SERIAL_ONE]     = serial_one_line;
        lines[tlie_pkg::BIT_SLEEP_TIMER]    = sleep_timer_line;
        lines[tlie_pkg::BIT_BASEBAND]       = baseband_line;
        lines[tlie_pkg::BIT_MANAGEMENT]     = management_line;
        lines[tlie_pkg::BIT_TIMER_TWO]      = tmr2.line;
        lines[tlie_pkg::BIT_TIMER_ONE]      = tmr1.line;
    end

    // write decode; bytes not enabled count as zero bits
    assign wd = cmd.wdata[tlie_pkg::LINE_W-1:0];
    assign wm = cmd.wmask[tlie_pkg::LINE_W-1:0];

    assign set_bits    = (cmd.wr_commit && cmd.addr == tlie_pkg::ADDR_EN_SET)
                         ? (wd & wm) : tlie_pkg::RESET_ENABLE;
    assign clr_bits    = (cmd.wr_commit && cmd.addr == tlie_pkg::ADDR_EN_CLEAR)
                         ? (wd & wm) : tlie_pkg::RESET_ENABLE;
    assign st_clr_bits = (cmd.wr_commit && cmd.addr == tlie_pkg::ADDR_IRQ_STATUS)
                         ? (wd & wm) : tlie_pkg::RESET_STATUS;

    assign tmr1.flag_clr_wr = cmd.wr_commit && cmd.addr == tlie_pkg::ADDR_TMR1_FLAG;
    assign tmr1.cfg_wr      = cmd.wr_commit && cmd.addr == tlie_pkg::ADDR_TMR1_CFG;
    assign tmr1.wdata       = cmd.wdata[tlie_pkg::TMR_W-1:0];
    assign tmr1.wmask       = cmd.wmask[tlie_pkg::TMR_W-1:0];
    assign tmr2.flag_clr_wr = cmd.wr_commit && cmd.addr == tlie_pkg::ADDR_TMR2_FLAG;
    assign tmr2.cfg_wr      = cmd.wr_commit && cmd.addr == tlie_pkg::ADDR_TMR2_CFG;
    assign tmr2.wdata       = cmd.wdata[tlie_pkg::TMR_W-1:0];
    assign tmr2.wmask       = cmd.wmask[tlie_pkg::TMR_W-1:0];

    // enable state; clear is applied after set so clear wins on one bit
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            enable_q <= tlie_pkg::RESET_ENABLE;
        else if (ce)
            enable_q <= (enable_q | set_bits) & ~clr_bits;
    end

    assign request = lines & enable_q;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            core_irq_q <= tlie_pkg::RESET_ENABLE;
        else if (ce)
            core_irq_q <= request;
    end

    // sticky status: a request in the clearing cycle keeps the bit set
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            status_q <= tlie_pkg::RESET_STATUS;
        else if (ce)
            status_q <= (status_q & ~st_clr_bits) | request;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            mask_q <= tlie_pkg::RESET_MASK;
        else if (ce && cmd.wr_commit && cmd.addr == tlie_pkg::ADDR_IRQ_MASK)
            mask_q <= (mask_q & ~wm) | (wd & wm);
    end

    // registered so the output never glitches; built from the next status value, so it changes on the same edge as status_q
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            irq_q <= 1'b0;
        else if (ce)
            irq_q <= |(((status_q & ~st_clr_bits) | request) & mask_q);
    end

    // read mux; unmapped addresses and reserved bits read zero
    always_comb
    begin
        rdata = tlie_pkg::READ_ZERO;
        unique case (cmd.addr)
            tlie_pkg::ADDR_EN_SET,
            tlie_pkg::ADDR_EN_CLEAR:   rdata[tlie_pkg::LINE_W-1:0] = enable_q;
            tlie_pkg::ADDR_TMR1_FLAG:  rdata[tlie_pkg::TMR_W-1:0]  = tmr1.flags;
            tlie_pkg::ADDR_TMR1_CFG:   rdata[tlie_pkg::TMR_W-1:0]  = tmr1.cfg;
            tlie_pkg::ADDR_TMR2_FLAG:  rdata[tlie_pkg::TMR_W-1:0]  = tmr2.flags;
            tlie_pkg::ADDR_TMR2_CFG:   rdata[tlie_pkg::TMR_W-1:0]  = tmr2.cfg;
            tlie_pkg::ADDR_IRQ_STATUS: rdata[tlie_pkg::LINE_W-1:0] = status_q;
            tlie_pkg::ADDR_IRQ_MASK:   rdata[tlie_pkg::LINE_W-1:0] = mask_q;
            default:                   rdata = tlie_pkg::READ_ZERO;
        endcase
    end

    assign cmd.rdata = rdata;
endmodule // tlie_top

// file: bench/tlie_src_model.sv
// peripheral source model: level lines and timer event strobes
`timescale 1ns/1ps
module tlie_src_model
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic [16:0] line_req,
    input  wire logic [6:0]  tmr1_req,
    input  wire logic [6:0]  tmr2_req,
    output logic      [16:0] lines_q,
    output logic      [6:0]  tmr1_q,
    output logic      [6:0]  tmr2_q
);
    // registered so every source changes just after an edge, like real peripherals
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            lines_q <= 17'h00000;
            tmr1_q  <= 7'h00;
            tmr2_q  <= 7'h00;
        end
        else
        begin
            lines_q <= line_req;
            tmr1_q  <= tmr1_req;
            tmr2_q  <= tmr2_req;
        end
    end
endmodule // tlie_src_model

// file: bench/tlie_top_chk.sv
// concurrent checks on the ports of the interrupt enable block
`timescale 1ns/1ps
module tlie_top_chk #(
    parameter int unsigned ADDR_W = 32
)
(
    input wire logic              clock,
    input wire logic              nrst,
    input wire logic              ce,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_writedata,
    input wire logic [3:0]        avs_byteenable,
    input wire logic [31:0]       avs_readdata,
    input wire logic              avs_waitrequest,
    input wire logic              debug_line,
    input wire logic [16:0]       core_irq_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_set_dbg;
        ce && avs_write && !avs_waitrequest && avs_byteenable[2] && avs_writedata[16]
            && avs_address == tlie_pkg::ADDR_EN_SET;
    endsequence
    sequence s_clr_dbg;
        ce && avs_write && !avs_waitrequest && avs_byteenable[2] && avs_writedata[16]
            && avs_address == tlie_pkg::ADDR_EN_CLEAR;
    endsequence
    property p_wait_one; ce && !avs_waitrequest |=> avs_waitrequest; endproperty
    property p_wait_req; !avs_waitrequest |-> avs_read || avs_write; endproperty
    property p_accept;
        ce && $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    property p_line_gate; ce && !debug_line |=> !core_irq_q[16]; endproperty
    property p_set_en; s_set_dbg ##1 (ce && debug_line) |=> core_irq_q[16]; endproperty
    property p_clr_en; s_clr_dbg ##1 ce |=> !core_irq_q[16]; endproperty
    property p_rd_upper;
        avs_read && !avs_waitrequest |-> avs_readdata[31:17] == 15'h0000;
    endproperty
    // only the top 20 address bits decide mapping here: a limitation, kept cheap
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address[31:12] != 20'hE000E
            |-> avs_readdata == 32'h00000000;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low longer than one cycle");
    a_wait_req: assert property (p_wait_req) else $error("accept without request");
    a_accept: assert property (p_accept) else $error("accept not after one wait");
    a_line_gate: assert property (p_line_gate) else $error("request without line");
    a_set_en: assert property (p_set_en) else $error("set enable not seen");
    a_clr_en: assert property (p_clr_en) else $error("clear enable not seen");
    a_rd_upper: assert property (p_rd_upper) else $error("reserved bits not zero");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // tlie_top_chk

bind tlie_top tlie_top_chk #(.ADDR_W(ADDR_W)) tlie_top_chk_inst (.clock, .nrst, .ce,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .debug_line, .core_irq_q);

// file: bench/tb_top_level_irq_enable.sv
// self-checking bench for the top-level interrupt enable block
`timescale 1ns/1ps
module tb_top_level_irq_enable;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        ce = 1'b1;
    logic [31:0] avs_address = 32'h00000000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [16:0] line_req = 17'h00000;
    logic [16:0] lines;
    logic [16:0] core_irq_q;
    logic [6:0]  tmr1_req = 7'h00;
    logic [6:0]  tmr2_req = 7'h00;
    logic [6:0]  t1;
    logic [6:0]  t2;
    logic        irq_q;
    logic [31:0] q;
    int          err_count = 0;
    int          total_checks = 0;
    // set data, clear data, line levels, enables expected afterwards
    logic [31:0] rows [5][4] = '{
        '{32'hFFFFFFFF, 32'h00000000, 32'h0001FFFC, 32'h0001FFFF},
        '{32'h00000000, 32'h00015555, 32'h0001FFFC, 32'h0000AAAA},
        '{32'h00001000, 32'h00000000, 32'h00005554, 32'h0000BAAA},
        '{32'h00000000, 32'hFFFE0000, 32'h0001FFFC, 32'h0000BAAA},
        '{32'h00010004, 32'h00010000, 32'h00010004, 32'h0000BAAE}};

    always #5 clock = ~clock;

    tlie_src_model tlie_src_model_inst (.clock, .nrst, .line_req, .tmr1_req, .tmr2_req,
        .lines_q(lines), .tmr1_q(t1), .tmr2_q(t2));

    tlie_top #(.ADDR_W(32)) tlie_top_inst (.clock, .nrst, .ce, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .debug_line(lines[16]), .ext_pin_d_line(lines[15]), .ext_pin_c_line(lines[14]),
        .ext_pin_b_line(lines[13]), .ext_pin_a_line(lines[12]), .converter_line(lines[11]),
        .radio_receive_line(lines[10]), .radio_transmit_line(lines[9]),
        .radio_timer_line(lines[8]), .security_line(lines[7]), .serial_two_line(lines[6]),
        .serial_one_line(lines[5]), .sleep_timer_line(lines[4]), .baseband_line(lines[3]),
        .management_line(lines[2]), .timer_two_source(t2), .timer_one_source(t1),
        .core_irq_q, .irq_q);

    task final_report;
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    // waitrequest is sampled at the rising edge, before that edge updates it
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d,
             input logic [3:0] be, output logic [31:0] rd);
        int n;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        avs_byteenable <= be;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
        begin
            err_count++;
            final_report;
        end
        else
        begin
            rd = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            // two edges: core_irq_q and irq_q follow a landed write by one edge
            repeat (2) @(posedge clock);
        end
    endtask

    initial
    begin
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        bus(1'b0, tlie_pkg::ADDR_EN_SET, 32'h0, 4'hF, q);
        chk(q, 32'h00000000);
        bus(1'b0, tlie_pkg::ADDR_EN_CLEAR, 32'h0, 4'hF, q);
        chk(q, 32'h00000000);
        for (int i = 0; i < 5; i++)
        begin
            line_req <= rows[i][2][16:0];
            bus(1'b1, tlie_pkg::ADDR_EN_SET, rows[i][0], 4'hF, q);
            bus(1'b1, tlie_pkg::ADDR_EN_CLEAR, rows[i][1], 4'hF, q);
            bus(1'b0, tlie_pkg::ADDR_EN_SET, 32'h0, 4'hF, q);
            chk(q, rows[i][3]);
            bus(1'b0, tlie_pkg::ADDR_EN_CLEAR, 32'h0, 4'hF, q);
            chk(q, rows[i][3]);
            chk({15'h0000, core_irq_q}, rows[i][3] & rows[i][2]);
        end
        // only lane 2 enabled: bit 16 set, the other lanes act as zero
        bus(1'b1, tlie_pkg::ADDR_EN_SET, 32'hFFFFFFFF, 4'h4, q);
        bus(1'b0, tlie_pkg::ADDR_EN_SET, 32'h0, 4'hF, q);
        chk(q, 32'h0001BAAE);
        bus(1'b1, 32'hE000E500, 32'hFFFFFFFF, 4'hF, q);
        bus(1'b0, 32'hE000E500, 32'h0, 4'hF, q);
        chk(q, 32'h00000000);
        bus(1'b0, 32'h00000100, 32'h0, 4'hF, q);
        chk(q, 32'h00000000);
        line_req <= 17'h00000;
        bus(1'b1, tlie_pkg::ADDR_EN_SET, 32'h00000003, 4'hF, q);
        bus(1'b1, tlie_pkg::ADDR_TMR1_CFG, 32'h0000005F, 4'hF, q);
        tmr1_req <= 7'h30;
        @(posedge clock);
        tmr1_req <= 7'h00;
        repeat (3) @(posedge clock);
        bus(1'b0, tlie_pkg::ADDR_TMR1_FLAG, 32'h0, 4'hF, q);
        chk(q, 32'h00000010);
        chk({31'h0, core_irq_q[0]}, 32'h1);
        bus(1'b1, tlie_pkg::ADDR_TMR1_FLAG, 32'h00000001, 4'hF, q);
        bus(1'b0, tlie_pkg::ADDR_TMR1_FLAG, 32'h0, 4'hF, q);
        chk(q, 32'h00000010);
        chk({31'h0, core_irq_q[0]}, 32'h1);
        bus(1'b1, tlie_pkg::ADDR_TMR1_FLAG, 32'h00000010, 4'hF, q);
        bus(1'b0, tlie_pkg::ADDR_TMR1_FLAG, 32'h0, 4'hF, q);
        chk(q, 32'h00000000);
        chk({31'h0, core_irq_q[0]}, 32'h0);
        tmr2_req <= 7'h40;
        @(posedge clock);
        tmr2_req <= 7'h00;
        repeat (3) @(posedge clock);
        bus(1'b0, tlie_pkg::ADDR_TMR2_FLAG, 32'h0, 4'hF, q);
        chk(q, 32'h00000040);
        chk({31'h0, core_irq_q[1]}, 32'h0);
        bus(1'b1, tlie_pkg::ADDR_TMR2_CFG, 32'h00000040, 4'hF, q);
        chk({31'h0, core_irq_q[1]}, 32'h1);
        bus(1'b1, tlie_pkg::ADDR_IRQ_MASK, 32'h00000002, 4'hF, q);
        chk({31'h0, irq_q}, 32'h1);
        bus(1'b1, tlie_pkg::ADDR_IRQ_MASK, 32'h00000000, 4'hF, q);
        chk({31'h0, irq_q}, 32'h0);
        bus(1'b1, tlie_pkg::ADDR_IRQ_MASK, 32'h00000002, 4'hF, q);
        bus(1'b1, tlie_pkg::ADDR_TMR2_FLAG, 32'h00000040, 4'hF, q);
        bus(1'b1, tlie_pkg::ADDR_IRQ_STATUS, 32'h00000002, 4'hF, q);
        bus(1'b0, tlie_pkg::ADDR_IRQ_STATUS, 32'h0, 4'hF, q);
        chk({31'h0, q[1]}, 32'h0);
        chk({31'h0, irq_q}, 32'h0);
        // an event while the clock enable is low must leave no flag behind
        ce <= 1'b0;
        tmr1_req <= 7'h01;
        @(posedge clock);
        tmr1_req <= 7'h00;
        repeat (3) @(posedge clock);
        ce <= 1'b1;
        @(posedge clock);
        bus(1'b0, tlie_pkg::ADDR_TMR1_FLAG, 32'h0, 4'hF, q);
        chk(q, 32'h00000000);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        bus(1'b0, tlie_pkg::ADDR_EN_CLEAR, 32'h0, 4'hF, q);
        chk(q, 32'h00000000);
        chk({14'h0000, irq_q, core_irq_q}, 32'h00000000);
        final_report;
    end
endmodule // tb_top_level_irq_enable
